// ===== asc_gain_resolve.sv
// Per-channel amplifier gain selection for slot A.
// Assumes combinational use inside the register block on the same clock.
`timescale 1ns/10ps
`default_nettype none
module asc_gain_resolve #(
    parameter int CHANNELS = 4
) (
    // Controls
    input wire logic ind_en_in,
    input wire logic [1:0] common_gain_in,
    input wire logic [2*(CHANNELS-1)-1:0] other_gain_in,
    // Result, two bits per channel, channel 1 lowest
    output logic [2*CHANNELS-1:0] gain_out
);
    // Channel 1 always follows the common field
    assign gain_out[1:0] = common_gain_in;
    genvar ch;
    generate
        for (ch = 1; ch < CHANNELS; ch++) begin : g_ch
            // Other channels take their own gain only when individual mode is on
            assign gain_out[2*ch+1:2*ch] = ind_en_in ?
                other_gain_in[2*ch-1:2*ch-2] : common_gain_in;
        end
    endgenerate
endmodule
`default_nettype wire

// ===== asc_pkg.sv
// Constants and carrier types for the slot front-end configuration registers.
// Assumes a single system clock domain and a 16-bit parallel register port.
package asc_pkg;
    // Register offsets
    localparam logic [7:0] OFS_SLOT_B_PULSE_POLARITY = 8'h1d;
    localparam logic [7:0] OFS_SLOT_B_INTEGRATION_WINDOW = 8'h3b;
    localparam logic [7:0] OFS_SLOT_A_AMPLIFIER_CONTROL = 8'h42;
    localparam logic [7:0] OFS_SLOT_A_PATH_SELECT = 8'h43;

    // Reset values
    localparam logic [15:0] RST_SLOT_B_PULSE_POLARITY = 16'h0000;
    localparam logic [4:0] RST_WINDOW_WIDTH = 5'h04;
    localparam logic [10:0] RST_WINDOW_OFFSET = 11'h017;
    localparam logic [5:0] RST_AMP_MODE = 6'h07;
    localparam logic [1:0] RST_AMP_REFERENCE = 2'h3;
    localparam logic [15:0] RST_SLOT_A_PATH_SELECT = 16'hada5;

    // Path select codes
    localparam logic [15:0] PATH_FULL_ANALOG = 16'hada5;
    localparam logic [15:0] PATH_AMP_CONV_BUF = 16'hae65;
    localparam logic [15:0] PATH_AMP_CONV_NOBUF = 16'hb065;

    // Field positions
    localparam int WIN_WIDTH_LSB = 11;
    localparam int WIN_WIDTH_MSB = 15;
    localparam int WIN_OFFSET_MSB = 10;
    localparam int POLARITY_MSB = 3;
    localparam int EXT_BUF_BIT = 7;

    // Timing: window width unit against the system clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int WIDTH_UNIT_NS = 1000;
    localparam int WIDTH_UNIT_CYCLES = WIDTH_UNIT_NS / CLK_PERIOD_NS;
    localparam int CHANNELS = 4;

    // Slot A amplifier control word layout
    typedef struct packed {
        logic [5:0] amp_mode;
        logic [1:0] int_gain;
        logic first_slot_integrator_buffer_sel;
        logic first_slot_individual_gain_en;
        logic [1:0] first_slot_amp_reference_sel;
        logic [1:0] spare;
        logic [1:0] first_slot_amp_gain;
    } asc_amp_ctrl_t;

    // Slot B integration window layout
    typedef struct packed {
        logic [4:0] second_slot_window_width;
        logic [10:0] second_slot_window_offset;
    } asc_window_t;

    typedef enum logic [1:0] {
        ASC_PATH_FULL,
        ASC_PATH_AMP_CONV,
        ASC_PATH_RESERVED
    } asc_path_mode_t;
endpackage

// ===== asc_slot_config_regs.sv
// Slot configuration register bank: slot A amplifier and path, slot B window.
// Assumes a same-clock parallel register port driven by the serial interface.
`timescale 1ns/10ps
`default_nettype none
module asc_slot_config_regs #(
    parameter int CHANNELS = asc_pkg::CHANNELS
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Neighbouring register bits
    input wire logic [2*(CHANNELS-1)-1:0] other_gain_in,
    input wire logic ext_buffer_cfg_in,
    // Slot B pulse sequencing from the timing core
    input wire logic slot_b_start_in,
    input wire logic slot_b_pulse_in,
    // Slot A analog controls
    output logic integrator_buffer_out,
    output logic [1:0] amp_reference_out,
    output logic [2*CHANNELS-1:0] amp_gain_out,
    output asc_pkg::asc_path_mode_t path_mode_out,
    output logic path_config_err_out,
    // Slot B analog controls
    output logic pulse_polarity_out,
    output logic [4:0] window_width_out,
    output logic [10:0] window_offset_out,
    output logic [9:0] window_width_cycles_out
);
    asc_pkg::asc_amp_ctrl_t amp_ctrl;
    asc_pkg::asc_window_t window;
    logic [15:0] polarity_word;
    logic [15:0] path_word;
    logic [1:0] pulse_idx;
    logic [2*CHANNELS-1:0] next_gain;
    asc_pkg::asc_path_mode_t next_mode;
    logic next_err;

    // Path word decode, used only by the path mode and error logic
    function automatic asc_pkg::asc_path_mode_t decode_path(input logic [15:0] w);
        if (w == asc_pkg::PATH_FULL_ANALOG) begin
            decode_path = asc_pkg::ASC_PATH_FULL;
        end else if (w == asc_pkg::PATH_AMP_CONV_BUF || w == asc_pkg::PATH_AMP_CONV_NOBUF) begin
            decode_path = asc_pkg::ASC_PATH_AMP_CONV;
        end else begin
            decode_path = asc_pkg::ASC_PATH_RESERVED;
        end
    endfunction

    function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] o);
        wr_hit = wr && (a == o);
    endfunction

    // Slot A amplifier control word
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            amp_ctrl <= '0;
            amp_ctrl.amp_mode <= asc_pkg::RST_AMP_MODE;
            amp_ctrl.first_slot_amp_reference_sel <= asc_pkg::RST_AMP_REFERENCE;
        end else if (wr_hit(reg_wr_in, reg_addr_in, asc_pkg::OFS_SLOT_A_AMPLIFIER_CONTROL)) begin
            amp_ctrl <= reg_wdata_in;
        end
    end

    // Slot A path select word
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            path_word <= asc_pkg::RST_SLOT_A_PATH_SELECT;
        end else if (wr_hit(reg_wr_in, reg_addr_in, asc_pkg::OFS_SLOT_A_PATH_SELECT)) begin
            path_word <= reg_wdata_in;
        end
    end

    // Slot B polarity and window words
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            polarity_word <= asc_pkg::RST_SLOT_B_PULSE_POLARITY;
            window.second_slot_window_width <= asc_pkg::RST_WINDOW_WIDTH;
            window.second_slot_window_offset <= asc_pkg::RST_WINDOW_OFFSET;
        end else begin
            if (wr_hit(reg_wr_in, reg_addr_in, asc_pkg::OFS_SLOT_B_PULSE_POLARITY)) begin
                polarity_word <= reg_wdata_in;
            end
            if (wr_hit(reg_wr_in, reg_addr_in, asc_pkg::OFS_SLOT_B_INTEGRATION_WINDOW)) begin
                window <= reg_wdata_in;
            end
        end
    end

    // Registered read port, unmapped addresses read zero
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    asc_pkg::OFS_SLOT_B_PULSE_POLARITY: reg_rdata_out <= polarity_word;
                    asc_pkg::OFS_SLOT_B_INTEGRATION_WINDOW: reg_rdata_out <= window;
                    asc_pkg::OFS_SLOT_A_AMPLIFIER_CONTROL: reg_rdata_out <= amp_ctrl;
                    asc_pkg::OFS_SLOT_A_PATH_SELECT: reg_rdata_out <= path_word;
                    default: reg_rdata_out <= 16'h0000;
                endcase
            end
        end
    end

    // Per-channel gain selection
    asc_gain_resolve #(
        .CHANNELS(CHANNELS)
    ) u_gain (
        .ind_en_in(amp_ctrl.first_slot_individual_gain_en),
        .common_gain_in(amp_ctrl.first_slot_amp_gain),
        .other_gain_in(other_gain_in),
        .gain_out(next_gain)
    );

    // Path mode and consistency with the buffer bits
    always_comb begin
        next_mode = decode_path(path_word);
        next_err = 1'b0;
        if (next_mode == asc_pkg::ASC_PATH_RESERVED) begin
            next_err = 1'b1;
        end else if (path_word == asc_pkg::PATH_AMP_CONV_BUF) begin
            next_err = !(amp_ctrl.first_slot_integrator_buffer_sel && ext_buffer_cfg_in);
        end else if (path_word == asc_pkg::PATH_AMP_CONV_NOBUF) begin
            next_err = amp_ctrl.first_slot_integrator_buffer_sel;
        end
    end

    // Registered slot A analog controls
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            integrator_buffer_out <= 1'b0;
            amp_reference_out <= asc_pkg::RST_AMP_REFERENCE;
            amp_gain_out <= '0;
            path_mode_out <= asc_pkg::ASC_PATH_FULL;
            path_config_err_out <= 1'b0;
        end else begin
            integrator_buffer_out <= amp_ctrl.first_slot_integrator_buffer_sel;
            amp_reference_out <= amp_ctrl.first_slot_amp_reference_sel;
            amp_gain_out <= next_gain;
            path_mode_out <= next_mode;
            path_config_err_out <= next_err;
        end
    end

    // Pulse index within the four-pulse group, restarted per slot
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pulse_idx <= 2'h0;
            pulse_polarity_out <= 1'b0;
        end else if (slot_b_start_in) begin
            pulse_idx <= 2'h0;
            pulse_polarity_out <= polarity_word[0];
        end else if (slot_b_pulse_in) begin
            pulse_idx <= pulse_idx + 2'h1;
            pulse_polarity_out <= polarity_word[2'(pulse_idx + 2'h1)];
        end
    end

    // Registered slot B window controls
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            window_width_out <= asc_pkg::RST_WINDOW_WIDTH;
            window_offset_out <= asc_pkg::RST_WINDOW_OFFSET;
            window_width_cycles_out <= 10'(asc_pkg::RST_WINDOW_WIDTH * asc_pkg::WIDTH_UNIT_CYCLES);
        end else begin
            window_width_out <= window.second_slot_window_width;
            window_offset_out <= window.second_slot_window_offset;
            window_width_cycles_out <=
                10'(window.second_slot_window_width * asc_pkg::WIDTH_UNIT_CYCLES);
        end
    end

    // Checks
    property p_buffer_follows;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        wr_hit(reg_wr_in, reg_addr_in, asc_pkg::OFS_SLOT_A_AMPLIFIER_CONTROL)
        |-> ##2 integrator_buffer_out == $past(reg_wdata_in[7], 2);
    endproperty
    a_buffer_follows: assert property (p_buffer_follows) else $error("buffer bit not applied");

    property p_individual_gain;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        ##1 $past(amp_ctrl.first_slot_individual_gain_en)
        |-> amp_gain_out[3:2] == $past(other_gain_in[1:0]);
    endproperty
    a_individual_gain: assert property (p_individual_gain) else $error("channel 2 gain wrong");

    property p_reference_default;
        @(posedge clk_sys_in) $rose(rst_n_in) |-> amp_reference_out == asc_pkg::RST_AMP_REFERENCE;
    endproperty
    a_reference_default: assert property (p_reference_default) else $error("reference default");

    property p_common_gain;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        ##1 !$past(amp_ctrl.first_slot_individual_gain_en)
        |-> amp_gain_out[7:6] == $past(amp_ctrl.first_slot_amp_gain);
    endproperty
    a_common_gain: assert property (p_common_gain) else $error("common gain not shared");

    property p_path_check;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (path_word == asc_pkg::PATH_AMP_CONV_NOBUF && amp_ctrl.first_slot_integrator_buffer_sel)
        ##1 $stable(path_word) |-> path_config_err_out;
    endproperty
    a_path_check: assert property (p_path_check) else $error("path conflict not flagged");

    property p_polarity_first;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        slot_b_start_in |=> pulse_polarity_out == $past(polarity_word[0]);
    endproperty
    a_polarity_first: assert property (p_polarity_first) else $error("first pulse polarity");

    property p_width_cycles;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        window_width_cycles_out == 10'(window_width_out * asc_pkg::WIDTH_UNIT_CYCLES);
    endproperty
    a_width_cycles: assert property (p_width_cycles) else $error("width cycles mismatch");

    property p_offset_default;
        @(posedge clk_sys_in) $rose(rst_n_in) |-> window_offset_out == asc_pkg::RST_WINDOW_OFFSET;
    endproperty
    a_offset_default: assert property (p_offset_default) else $error("offset default");

    property p_readback;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_wr_in && reg_addr_in == asc_pkg::OFS_SLOT_A_PATH_SELECT)
        ##1 (reg_rd_in && reg_addr_in == asc_pkg::OFS_SLOT_A_PATH_SELECT && !reg_wr_in)
        |=> reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");
endmodule
`default_nettype wire

// ===== tb_asc_slot_config_regs.sv
// Self-checking testbench for the slot configuration register bank.
// Assumes the bank's own assertions live in the design files.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_sys_in, rst_n_in, reg_wr, reg_rd, rvalid, ext_buf, start_s, pulse_s;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, rdata;
    logic [5:0] other_gain;
    logic int_buf, path_err, pol;
    logic [1:0] amp_ref;
    logic [7:0] amp_gain;
    asc_pkg::asc_path_mode_t path_mode;
    logic [4:0] win_w;
    logic [10:0] win_o;
    logic [9:0] win_cyc;
    int fails, comparisons;

    // Design under test
    asc_slot_config_regs DUT (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .other_gain_in(other_gain), .ext_buffer_cfg_in(ext_buf),
        .slot_b_start_in(start_s), .slot_b_pulse_in(pulse_s),
        .integrator_buffer_out(int_buf), .amp_reference_out(amp_ref),
        .amp_gain_out(amp_gain), .path_mode_out(path_mode),
        .path_config_err_out(path_err), .pulse_polarity_out(pol),
        .window_width_out(win_w), .window_offset_out(win_o),
        .window_width_cycles_out(win_cyc));

    // Clock, 50 ns period
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    // Counts and reports one comparison
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One write, then one edge for derived outputs
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys_in);
        #1 reg_wr = 1'b0;
        @(posedge clk_sys_in);
        #1;
    endtask

    // One read with data and strobe checks
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys_in);
        #1 reg_rd = 1'b0;
        check("rvalid", {15'h0, rvalid}, 16'h1);
        check("rdata", rdata, exp);
        @(posedge clk_sys_in);
        #1 check("rvalid_drop", {15'h0, rvalid}, 16'h0);
    endtask

    // Defaults after any reset
    task automatic reset_values();
        rd(asc_pkg::OFS_SLOT_B_PULSE_POLARITY, 16'h0000);
        rd(asc_pkg::OFS_SLOT_B_INTEGRATION_WINDOW, 16'h2017);
        rd(asc_pkg::OFS_SLOT_A_AMPLIFIER_CONTROL, 16'h1c30);
        rd(asc_pkg::OFS_SLOT_A_PATH_SELECT, 16'hada5);
        check("buffer", {15'h0, int_buf}, 16'h0);
        check("reference", {14'h0, amp_ref}, 16'h3);
        check("gain", {8'h0, amp_gain}, 16'h0);
        check("mode", {14'h0, path_mode}, {14'h0, asc_pkg::ASC_PATH_FULL});
        check("path_err", {15'h0, path_err}, 16'h0);
        check("width", {11'h0, win_w}, 16'h4);
        check("offset", {5'h0, win_o}, 16'h17);
        check("width_cycles", {6'h0, win_cyc}, 16'h0050);
        check("polarity", {15'h0, pol}, 16'h0000);
    endtask

    // Every reference and gain code, buffer and individual enable varied
    task automatic amp_codes();
        logic [15:0] d;
        for (int r = 0; r < 4; r++) begin
            for (int g = 0; g < 4; g++) begin
                d = {8'h1c, r[0], g[0], 2'(r), 2'h0, 2'(g)};
                wr(asc_pkg::OFS_SLOT_A_AMPLIFIER_CONTROL, d);
                check("buffer", {15'h0, int_buf}, {15'h0, d[7]});
                check("reference", {14'h0, amp_ref}, 16'(r));
                if (d[6]) begin
                    check("gain_ind", {8'h0, amp_gain}, {8'h0, other_gain, d[1:0]});
                end else begin
                    check("gain_all", {8'h0, amp_gain}, {8'h0, {4{d[1:0]}}});
                end
                rd(asc_pkg::OFS_SLOT_A_AMPLIFIER_CONTROL, d);
            end
        end
    endtask

    // One path select case against buffer bits
    task automatic path_case(input logic b7, input logic ext, input logic [15:0] code,
                             input logic [1:0] mode, input logic err, input logic see_mode);
        ext_buf = ext;
        wr(asc_pkg::OFS_SLOT_A_AMPLIFIER_CONTROL, {8'h1c, b7, 7'h30});
        wr(asc_pkg::OFS_SLOT_A_PATH_SELECT, code);
        check("path_err", {15'h0, path_err}, {15'h0, err});
        if (see_mode) begin
            check("mode", {14'h0, path_mode}, {14'h0, mode});
        end
        rd(asc_pkg::OFS_SLOT_A_PATH_SELECT, code);
    endtask

    // Path codes, consistent and not
    task automatic path_codes();
        path_case(1'b1, 1'b1, 16'hae65, asc_pkg::ASC_PATH_AMP_CONV, 1'b0, 1'b1);
        path_case(1'b1, 1'b0, 16'hae65, asc_pkg::ASC_PATH_AMP_CONV, 1'b1, 1'b0);
        path_case(1'b0, 1'b1, 16'hb065, asc_pkg::ASC_PATH_AMP_CONV, 1'b0, 1'b1);
        path_case(1'b1, 1'b0, 16'hb065, asc_pkg::ASC_PATH_AMP_CONV, 1'b1, 1'b0);
        path_case(1'b0, 1'b0, 16'hada6, asc_pkg::ASC_PATH_RESERVED, 1'b1, 1'b1);
        path_case(1'b0, 1'b0, 16'hada5, asc_pkg::ASC_PATH_FULL, 1'b0, 1'b1);
    endtask

    // Polarity walk over a pulse group with wrap and restart
    task automatic polarity_walk();
        logic [15:0] pat;
        // Bit 0 differs from bit 2, so a missed restart shows
        pat = 16'h0009;
        wr(asc_pkg::OFS_SLOT_B_PULSE_POLARITY, pat);
        start_s = 1'b1;
        for (int i = 0; i < 7; i++) begin
            pulse_s = (i != 0);
            @(posedge clk_sys_in);
            #1 start_s = (i == 5);
            check("polarity", {15'h0, pol}, {15'h0, pat[(i == 6) ? 0 : i % 4]});
        end
        pulse_s = 1'b0;
    endtask

    // Write then read on the next edge; read alongside a write returns the old word
    task automatic back_to_back();
        reg_addr = asc_pkg::OFS_SLOT_A_PATH_SELECT;
        reg_wdata = 16'hb065;
        reg_wr = 1'b1;
        @(posedge clk_sys_in);
        #1 reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(posedge clk_sys_in);
        #1 reg_wr = 1'b1;
        reg_wdata = 16'hada5;
        check("rdata_next", rdata, 16'hb065);
        @(posedge clk_sys_in);
        #1 reg_wr = 1'b0;
        check("rdata_same_edge", rdata, 16'hb065);
        @(posedge clk_sys_in);
        #1 reg_rd = 1'b0;
        check("rdata_after", rdata, 16'hada5);
        check("rvalid_b2b", {15'h0, rvalid}, 16'h1);
        @(posedge clk_sys_in);
        #1;
    endtask

    // Window boundary values, unmapped access
    task automatic window_fields();
        logic [15:0] v [2] = '{16'hf801, 16'h0fff};
        foreach (v[i]) begin
            wr(asc_pkg::OFS_SLOT_B_INTEGRATION_WINDOW, v[i]);
            check("width", {11'h0, win_w}, {11'h0, v[i][15:11]});
            check("offset", {5'h0, win_o}, {5'h0, v[i][10:0]});
            check("width_cycles", {6'h0, win_cyc}, 16'(v[i][15:11] * 20));
            rd(asc_pkg::OFS_SLOT_B_INTEGRATION_WINDOW, v[i]);
        end
        wr(8'h44, 16'hffff);
        rd(8'h44, 16'h0000);
        rd(asc_pkg::OFS_SLOT_B_INTEGRATION_WINDOW, 16'h0fff);
    endtask

    // Watchdog
    initial begin
        repeat (6000) @(posedge clk_sys_in);
        fails++;
        complete_run();
    end

    // Main sequence
    initial begin
        fails = 0;
        comparisons = 0;
        rst_n_in = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        other_gain = 6'h1b;
        ext_buf = 1'b0;
        start_s = 1'b0;
        pulse_s = 1'b0;
        repeat (20) @(posedge clk_sys_in);
        #1 rst_n_in = 1'b1;
        reset_values();
        amp_codes();
        path_codes();
        back_to_back();
        polarity_walk();
        window_fields();
        // Mid-run reset must reload every default
        rst_n_in = 1'b0;
        @(posedge clk_sys_in);
        #1 rst_n_in = 1'b1;
        reset_values();
        complete_run();
    end
endmodule
`default_nettype wire
